// ---- core/fault_pkg.sv ----
// Shared constants for the motor driver fault protection block.
package fault_pkg;
  // Clock period in ns
  localparam int CLK_NS = 25;
  localparam int FET_N = 6;
  localparam int DEG_W = 9;
  localparam int RETRY_W = 18;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] LIM_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h0c;

  // Protection config fields
  localparam int OVERVOLTAGE_PROTECT_ENABLE_BIT = 0;
  localparam int OVERVOLTAGE_THRESHOLD_SELECT_BIT = 1;
  localparam int OVERCURRENT_RESPONSE_MODE_LSB = 2;
  localparam int OVERCURRENT_LEVEL_LSB = 4;
  localparam int OVERCURRENT_DEGLITCH_LSB = 8;
  localparam int OVERCURRENT_RETRY_TIME_BIT = 10;
  // Cycle limit config fields, then the clear bit of the command register
  localparam int CBC_MODE_LSB = 0;
  localparam int CBC_RETRY_LSB = 4;
  localparam int CBC_LIM_LSB = 8;
  localparam int OL_LIM_LSB = 16;
  localparam int CLR_BIT = 0;

  // Reset values: protection off, latched overcurrent, cycle limit disabled
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] LIM_RST = 32'h0000_0007;

  // Overcurrent modes
  localparam logic [1:0] OCP_LATCH = 2'h0;
  localparam logic [1:0] OVERCURRENT_RETRY_TIME = 2'h1;
  localparam logic [1:0] OCP_REPORT = 2'h2;
  localparam logic [1:0] OCP_OFF = 2'h3;
  // Cycle limit report-only code
  localparam logic [3:0] CBC_REPORT = 4'h6;

  // Deglitch times in ns and their cycle counts (least time, rounded up)
  localparam int DEG_NS_0 = 1000;
  localparam int DEG_NS_1 = 2000;
  localparam int DEG_NS_2 = 5000;
  localparam int DEG_NS_3 = 10000;
  localparam logic [DEG_W-1:0] DEG_CYC_0 = DEG_W'((DEG_NS_0 + CLK_NS - 1) / CLK_NS);
  localparam logic [DEG_W-1:0] DEG_CYC_1 = DEG_W'((DEG_NS_1 + CLK_NS - 1) / CLK_NS);
  localparam logic [DEG_W-1:0] DEG_CYC_2 = DEG_W'((DEG_NS_2 + CLK_NS - 1) / CLK_NS);
  localparam logic [DEG_W-1:0] DEG_CYC_3 = DEG_W'((DEG_NS_3 + CLK_NS - 1) / CLK_NS);

  // Overcurrent retry times in us and default cycle counts
  localparam int RETRY_SHORT_US = 500;
  localparam int RETRY_LONG_US = 5000;
  localparam int RETRY_SHORT_DEF = (RETRY_SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_LONG_DEF = (RETRY_LONG_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Index of each analog input in the filter bank
  localparam int IN_VM_UV = 0;
  localparam int IN_ANALOG_RAIL_UNDERVOLTAGE = 1;
  localparam int IN_BUCK_UNDERVOLTAGE = 2;
  localparam int IN_PUMP_UV = 3;
  localparam int IN_OV_LO = 4;
  localparam int IN_OV_HI = 5;
  localparam int IN_LIMIT = 6;
  localparam int IN_BUCK_OC = 7;
  localparam int IN_FET0 = 8;
  localparam int NUM_IN = IN_FET0 + FET_N;
endpackage

// ---- core/pin_filter.sv ----
// Two-flop synchroniser followed by a continuous-high deglitch counter.
`timescale 1ns/1ps
module pin_filter #(
  parameter int CNT_W = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  input wire logic [CNT_W-1:0] limit,
  output logic level
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic [CNT_W-1:0] cnt;
    logic level;
  } filt_type;

  filt_type filt_reg;
  filt_type filt_next;

  // Count only while the synced level stays high; any dip restarts it
  always_comb begin
    filt_next = filt_reg;
    filt_next.meta = pin;
    filt_next.sync = filt_reg.meta;
    if (!filt_reg.sync) begin
      filt_next.cnt = '0;
    end else if (filt_reg.cnt != '1) begin
      filt_next.cnt = filt_reg.cnt + 1'b1;
    end
    filt_next.level = filt_reg.sync && (filt_reg.cnt >= limit);
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_reg <= '0;
    end else if (ce) begin
      filt_reg <= filt_next;
    end
  end

  assign level = filt_reg.level;
endmodule

// ---- core/fault_protect.sv ----
// Fault response logic of a three-phase motor driver.
`timescale 1ns/1ps
module fault_protect
  import fault_pkg::*;
#(
  parameter int RETRY_SHORT_CYC = RETRY_SHORT_DEF,
  parameter int RETRY_LONG_CYC = RETRY_LONG_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] read_data,
  input wire logic supply_undervoltage_lockout,
  input wire logic analog_rail_undervoltage,
  input wire logic buck_undervoltage,
  input wire logic pump_undervoltage,
  input wire logic vm_above_low_level,
  input wire logic vm_above_high_level,
  input wire logic [FET_N-1:0] fet_overcurrent,
  input wire logic buck_overcurrent,
  input wire logic limit_comparator_hit,
  input wire logic closed_loop,
  input wire logic pwm_cycle_start,
  output logic fault_indicator_n,
  output logic fet_disable,
  output logic fet_recirculate,
  output logic device_reset,
  output logic pump_disable,
  output logic buck_switches_off,
  output logic overvoltage_threshold_select,
  output logic [3:0] overcurrent_level,
  output logic [7:0] limit_threshold
);
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] lim;
    logic drv_flt;
    logic pump_flg;
    logic ov_flg;
    logic oc_flg;
    logic ctl_flt;
    logic cbc_flg;
    logic [FET_N-1:0] fet_flg;
    logic oc_latch;
    logic retry_on;
    logic [RETRY_W-1:0] retry_cnt;
    logic cbc_on;
    logic cbc_pin;
    logic [3:0] cbc_cnt;
    logic fet_off;
    logic recirc;
    logic pin_low;
    logic supply_rst;
    logic buck_off;
    logic [7:0] thr;
    logic [31:0] rdata;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] filt;
  logic [DEG_W-1:0] deg_lim;
  logic [1:0] overcurrent_response_mode;
  logic [3:0] cbc_mode;
  logic [FET_N-1:0] fet_oc;
  logic oc_any;
  logic ov_act;
  logic supply_evt;
  logic limit_hit;
  logic clr;
  logic [31:0] status;

  // Gather the asynchronous analog comparator outputs
  assign raw_in = {fet_overcurrent, buck_overcurrent, limit_comparator_hit,
                   vm_above_high_level, vm_above_low_level, pump_undervoltage,
                   buck_undervoltage, analog_rail_undervoltage, supply_undervoltage_lockout};

  // Deglitch count picked by the two-bit deglitch field
  assign deg_lim = (state_reg.cfg[OVERCURRENT_DEGLITCH_LSB +: 2] == 2'h0) ? DEG_CYC_0 :
                   (state_reg.cfg[OVERCURRENT_DEGLITCH_LSB +: 2] == 2'h1) ? DEG_CYC_1 :
                   (state_reg.cfg[OVERCURRENT_DEGLITCH_LSB +: 2] == 2'h2) ? DEG_CYC_2 : DEG_CYC_3;

  // Every input is synchronised; only the buck and FET overcurrent inputs get a deglitch window
  for (genvar i = 0; i < NUM_IN; i++) begin : g_filt
    pin_filter #(
      .CNT_W(DEG_W)
    ) u_filt (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .pin(raw_in[i]),
      .limit((i >= IN_BUCK_OC) ? deg_lim : '0),
      .level(filt[i])
    );
  end

  // Decoded conditions
  assign overcurrent_response_mode = state_reg.cfg[OVERCURRENT_RESPONSE_MODE_LSB +: 2];
  assign cbc_mode = state_reg.lim[CBC_MODE_LSB +: 4];
  assign fet_oc = filt[IN_FET0 +: FET_N];
  assign oc_any = |fet_oc;
  assign limit_hit = filt[IN_LIMIT];
  assign supply_evt = filt[IN_VM_UV] | filt[IN_ANALOG_RAIL_UNDERVOLTAGE] | filt[IN_BUCK_UNDERVOLTAGE] | filt[IN_BUCK_OC];
  assign ov_act = state_reg.cfg[OVERVOLTAGE_PROTECT_ENABLE_BIT] &&
                  (state_reg.cfg[OVERVOLTAGE_THRESHOLD_SELECT_BIT] ? filt[IN_OV_HI] : filt[IN_OV_LO]);
  assign clr = write_strobe && (addr == CMD_OFS) && write_data[CLR_BIT];
  assign status = {18'h0, state_reg.recirc, state_reg.fet_off, state_reg.fet_flg,
                   state_reg.cbc_flg, state_reg.ctl_flt, state_reg.oc_flg,
                   state_reg.ov_flg, state_reg.pump_flg, state_reg.drv_flt};

  // Next state: bus, flags, recovery timers and output drive
  always_comb begin
    state_next = state_reg;
    state_next.rdata = '0;
    // Register writes; reads answer in the following cycle only
    if (write_strobe) begin
      if (addr == CFG_OFS) begin
        state_next.cfg = write_data;
      end else if (addr == LIM_OFS) begin
        state_next.lim = write_data;
      end
    end
    if (read_strobe) begin
      if (addr == CFG_OFS) begin
        state_next.rdata = state_reg.cfg;
      end else if (addr == LIM_OFS) begin
        state_next.rdata = state_reg.lim;
      end else if (addr == STAT_OFS) begin
        state_next.rdata = status;
      end
    end
    if (supply_evt) begin
      // Whole-device reset: config and flags back to reset values
      state_next = '0;
      state_next.cfg = CFG_RST;
      state_next.lim = LIM_RST;
      state_next.fet_off = 1'b1;
      state_next.supply_rst = 1'b1;
      state_next.buck_off = filt[IN_BUCK_UNDERVOLTAGE];
    end else begin
      // Reset outputs follow the event; without this they would stick high forever
      state_next.supply_rst = 1'b0;
      state_next.buck_off = 1'b0;
      // Clear first so that a live condition sets the flag again
      if (clr) begin
        state_next.drv_flt = 1'b0;
        state_next.pump_flg = 1'b0;
        state_next.ov_flg = 1'b0;
        state_next.oc_flg = 1'b0;
        state_next.fet_flg = '0;
        state_next.oc_latch = 1'b0;
        state_next.ctl_flt = 1'b0;
        if (cbc_mode == CBC_REPORT) begin
          state_next.cbc_flg = 1'b0;
        end
      end
      // Charge pump undervoltage
      if (filt[IN_PUMP_UV]) begin
        state_next.drv_flt = 1'b1;
        state_next.pump_flg = 1'b1;
      end
      // Supply overvoltage
      if (ov_act) begin
        state_next.drv_flt = 1'b1;
        state_next.ov_flg = 1'b1;
      end
      // Retry timer runs down and then releases the FETs
      if (state_reg.retry_on) begin
        if (state_reg.retry_cnt == '0) begin
          state_next.retry_on = 1'b0;
        end else begin
          state_next.retry_cnt = state_reg.retry_cnt - 1'b1;
        end
      end
      // FET overcurrent after deglitch
      if (oc_any && (overcurrent_response_mode != OCP_OFF)) begin
        state_next.drv_flt = 1'b1;
        state_next.oc_flg = 1'b1;
        state_next.fet_flg = state_next.fet_flg | fet_oc;
        if (overcurrent_response_mode == OCP_LATCH) begin
          state_next.oc_latch = 1'b1;
        end
        if ((overcurrent_response_mode == OVERCURRENT_RETRY_TIME) && !state_reg.retry_on) begin
          state_next.retry_on = 1'b1;
          state_next.retry_cnt = state_reg.cfg[OVERCURRENT_RETRY_TIME_BIT] ?
                                 RETRY_W'(RETRY_LONG_CYC - 1) : RETRY_W'(RETRY_SHORT_CYC - 1);
        end
      end
      // Release of an active cycle limit, by recovery family
      if (state_reg.cbc_on) begin
        if (cbc_mode[3:1] == 3'h0) begin
          if (pwm_cycle_start) begin
            state_next.cbc_on = 1'b0;
            state_next.cbc_pin = 1'b0;
            state_next.cbc_flg = 1'b0;
          end
        end else if (cbc_mode[3:1] == 3'h1) begin
          if (!limit_hit) begin
            state_next.cbc_on = 1'b0;
            state_next.cbc_pin = 1'b0;
            state_next.cbc_flg = 1'b0;
          end
        end else if (cbc_mode[3:1] == 3'h2) begin
          if (pwm_cycle_start) begin
            if (state_reg.cbc_cnt == 4'h0) begin
              state_next.cbc_on = 1'b0;
              state_next.cbc_pin = 1'b0;
              state_next.cbc_flg = 1'b0;
            end else begin
              state_next.cbc_cnt = state_reg.cbc_cnt - 1'b1;
            end
          end
        end else begin
          // Mode changed to a passive one: stop recirculating
          state_next.cbc_on = 1'b0;
          state_next.cbc_pin = 1'b0;
        end
      end
      // New limit event; the set wins over a release in the same cycle
      if (limit_hit) begin
        if (cbc_mode <= 4'h5) begin
          if (!state_next.cbc_on) begin
            state_next.cbc_cnt = state_reg.lim[CBC_RETRY_LSB +: 4];
          end
          state_next.cbc_on = 1'b1;
          state_next.cbc_flg = 1'b1;
          if (!cbc_mode[0]) begin
            state_next.cbc_pin = 1'b1;
            state_next.ctl_flt = 1'b1;
          end
        end else if (cbc_mode == CBC_REPORT) begin
          state_next.cbc_flg = 1'b1;
          state_next.ctl_flt = 1'b1;
        end
      end
      // Output drive derived from the settled fault state
      state_next.fet_off = filt[IN_PUMP_UV] | ov_act | state_next.oc_latch |
                           state_next.retry_on;
      state_next.recirc = state_next.cbc_on & ~state_next.fet_off;
      state_next.pin_low = filt[IN_PUMP_UV] | ov_act | state_next.oc_latch |
                           state_next.retry_on | state_next.cbc_pin;
    end
    // Analog limit reference follows the loop state
    state_next.thr = closed_loop ? state_reg.lim[CBC_LIM_LSB +: 8] :
                     state_reg.lim[OL_LIM_LSB +: 8];
  end

  // One register for the whole state; ce freezes it
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.cfg <= CFG_RST;
      state_reg.lim <= LIM_RST;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Outputs, all straight from flip-flops
  assign read_data = state_reg.rdata;
  assign fault_indicator_n = ~state_reg.pin_low;
  assign fet_disable = state_reg.fet_off;
  assign fet_recirculate = state_reg.recirc;
  assign device_reset = state_reg.supply_rst;
  assign pump_disable = state_reg.supply_rst;
  assign buck_switches_off = state_reg.buck_off;
  assign overvoltage_threshold_select = state_reg.cfg[OVERVOLTAGE_THRESHOLD_SELECT_BIT];
  assign overcurrent_level = state_reg.cfg[OVERCURRENT_LEVEL_LSB +: 4];
  assign limit_threshold = state_reg.thr;

  // Checks run only while the block is clocked and out of reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !ce);

  a_supply_reset: assert property (
    filt[IN_VM_UV] |=> device_reset && fet_disable && pump_disable)
    else $error("supply undervoltage did not reset");
  a_rail_reset: assert property (
    filt[IN_ANALOG_RAIL_UNDERVOLTAGE] |=> device_reset && fet_disable && fault_indicator_n)
    else $error("rail undervoltage did not reset");
  a_buck_undervoltage_off: assert property (
    filt[IN_BUCK_UNDERVOLTAGE] |=> buck_switches_off && device_reset)
    else $error("buck switches not off");
  a_buck_oc_reset: assert property (
    filt[IN_BUCK_OC] |=> device_reset)
    else $error("buck overcurrent did not reset");
  a_pump_trip: assert property (
    filt[IN_PUMP_UV] && !supply_evt |=> !fault_indicator_n && fet_disable && state_reg.pump_flg)
    else $error("pump undervoltage not handled");
  a_pump_sticky: assert property (
    state_reg.pump_flg && !clr && !supply_evt |=> state_reg.pump_flg)
    else $error("pump flag lost without clear");
  a_ovp_gate: assert property (
    $rose(state_reg.ov_flg) |-> $past(state_reg.cfg[OVERVOLTAGE_PROTECT_ENABLE_BIT]))
    else $error("overvoltage flagged while disabled");
  a_ovp_trip: assert property (
    state_reg.cfg[OVERVOLTAGE_PROTECT_ENABLE_BIT] && !state_reg.cfg[OVERVOLTAGE_THRESHOLD_SELECT_BIT] && filt[IN_OV_LO] && !supply_evt
    |=> fet_disable && !fault_indicator_n && state_reg.ov_flg)
    else $error("low overvoltage level not acted on");
  a_oc_latch_hold: assert property (
    state_reg.oc_latch && !clr && !supply_evt |=> state_reg.oc_latch && fet_disable)
    else $error("latched overcurrent released early");
  a_oc_retry_drive: assert property (
    $rose(state_reg.retry_on) |-> fet_disable && !fault_indicator_n)
    else $error("retry start without FET disable");
  a_oc_report_run: assert property (
    overcurrent_response_mode == OCP_REPORT && oc_any && !state_reg.retry_on && !state_reg.oc_latch && !supply_evt
    |=> state_reg.oc_flg && state_reg.fet_flg != '0)
    else $error("report mode did not flag");
  a_oc_off_quiet: assert property (
    $rose(state_reg.oc_flg) |-> $past(overcurrent_response_mode) != OCP_OFF)
    else $error("overcurrent flagged while off");
  a_cbc_next_cycle: assert property (
    state_reg.cbc_on && cbc_mode[3:1] == 3'h0 && pwm_cycle_start && !limit_hit && !supply_evt
    |=> !state_reg.cbc_on && !state_reg.cbc_flg && !fet_recirculate)
    else $error("next-cycle recovery missed");
  a_cbc_pin_low: assert property (
    state_reg.cbc_pin |-> !fault_indicator_n)
    else $error("limit report pin not low");
  a_cbc_threshold: assert property (
    state_reg.cbc_on && cbc_mode[3:1] == 3'h1 && !limit_hit && !supply_evt |=> !state_reg.cbc_on)
    else $error("threshold recovery missed");

  c_retry_done: cover property ($fell(state_reg.retry_on));
  c_cbc_next: cover property ($fell(state_reg.cbc_on) && cbc_mode == 4'h0);
  c_ov_trip: cover property ($rose(state_reg.ov_flg));
  c_count_done: cover property ($fell(state_reg.cbc_on) && cbc_mode == 4'h4);
endmodule

// ---- tb/fault_host.sv ----
// Bus-side model of the external controller that reads fault flags and issues clears.
`timescale 1ns/1ps
module fault_host
  import fault_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] addr,
  output logic [31:0] write_data,
  output logic write_strobe,
  output logic read_strobe,
  input wire logic [31:0] read_data
);
  // Idle bus at time zero
  initial begin
    addr = '0;
    write_data = '0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
  end

  // One-cycle write; data inverted afterwards so a stale word is never mistaken for fresh
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
    write_data <= ~d;
  endtask

  // One-cycle read; the answer stands only in the cycle after the strobe
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1;
    d = read_data;
  endtask

  // Look at the flags, then clear once the caller has removed the cause
  task automatic clear_faults();
    logic [31:0] s;
    read_reg(STAT_OFS, s);
    if (s !== 32'h0) begin
      write_reg(CMD_OFS, 32'h1 << CLR_BIT);
    end
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking testbench for the motor driver fault protection block.
`timescale 1ns/1ps
module tb;
  import fault_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cl = 1'b1;
  logic pwm = 1'b0;
  logic [7:0] lv = 8'h00;
  logic [FET_N-1:0] foc = '0;
  logic [ADDR_W-1:0] addr;
  logic [31:0] write_data, read_data, rd;
  logic write_strobe, read_strobe, act, rep, still;
  logic fault_indicator_n, fet_disable, fet_recirculate, device_reset, pump_disable, buck_switches_off;
  logic overvoltage_threshold_select;
  logic [3:0] overcurrent_level;
  logic [7:0] limit_threshold;
  int fails = 0;
  int total_checks = 0;
  int srcs[4] = '{IN_VM_UV, IN_ANALOG_RAIL_UNDERVOLTAGE, IN_BUCK_UNDERVOLTAGE, IN_BUCK_OC};

  // Short retry counts keep the run brief
  fault_protect #(.RETRY_SHORT_CYC(20), .RETRY_LONG_CYC(200)) dut (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .supply_undervoltage_lockout(lv[IN_VM_UV]), .analog_rail_undervoltage(lv[IN_ANALOG_RAIL_UNDERVOLTAGE]),
    .buck_undervoltage(lv[IN_BUCK_UNDERVOLTAGE]), .pump_undervoltage(lv[IN_PUMP_UV]),
    .vm_above_low_level(lv[IN_OV_LO]), .vm_above_high_level(lv[IN_OV_HI]),
    .fet_overcurrent(foc), .buck_overcurrent(lv[IN_BUCK_OC]), .limit_comparator_hit(lv[IN_LIMIT]),
    .closed_loop(cl), .pwm_cycle_start(pwm), .fault_indicator_n(fault_indicator_n),
    .fet_disable(fet_disable), .fet_recirculate(fet_recirculate), .device_reset(device_reset),
    .pump_disable(pump_disable), .buck_switches_off(buck_switches_off),
    .overvoltage_threshold_select(overvoltage_threshold_select),
    .overcurrent_level(overcurrent_level), .limit_threshold(limit_threshold)
  );

  fault_host host (
    .clk(clk), .addr(addr), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  // Wait some edges, then look once the edge's updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic setc(input int i, input logic v);
    @(posedge clk);
    lv[i] <= v;
  endtask

  task automatic setf(input logic [FET_N-1:0] v);
    @(posedge clk);
    foc <= v;
  endtask

  task automatic pulse_pwm();
    @(posedge clk);
    pwm <= 1'b1;
    @(posedge clk);
    pwm <= 1'b0;
  endtask

  task automatic pins(input logic fd, input logic fn, input logic rc);
    check({29'h0, fet_disable, fault_indicator_n, fet_recirculate}, {29'h0, fd, fn, rc}, "pins");
  endtask

  task automatic stat(input logic [31:0] e);
    host.read_reg(STAT_OFS, rd);
    check(rd, e, "status");
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped and read-only places, bus ignored while ce is low
    host.read_reg(CFG_OFS, rd);
    check(rd, CFG_RST, "cfg reset");
    host.read_reg(LIM_OFS, rd);
    check(rd, LIM_RST, "lim reset");
    host.write_reg(8'h10, 32'hffff_ffff);
    host.read_reg(8'h10, rd);
    check(rd, 32'h0, "unmapped");
    host.write_reg(STAT_OFS, 32'h0000_ffff);
    stat(32'h0);
    @(posedge clk);
    ce <= 1'b0;
    host.write_reg(CFG_OFS, 32'h1);
    @(posedge clk);
    ce <= 1'b1;
    host.read_reg(CFG_OFS, rd);
    check(rd, 32'h0, "ce low write");
    // Pump undervoltage: drive stops while it lasts, its flag stays
    setc(IN_PUMP_UV, 1'b1);
    settle(6);
    pins(1'b1, 1'b0, 1'b0);
    stat(32'h0000_1003);
    setc(IN_PUMP_UV, 1'b0);
    settle(6);
    pins(1'b0, 1'b1, 1'b0);
    stat(32'h0000_0003);
    host.clear_faults();
    stat(32'h0);
    // Overvoltage ignored while disabled, then both threshold choices
    setc(IN_OV_LO, 1'b1);
    setc(IN_OV_HI, 1'b1);
    settle(6);
    pins(1'b0, 1'b1, 1'b0);
    stat(32'h0);
    host.write_reg(CFG_OFS, 32'h1);
    settle(6);
    pins(1'b1, 1'b0, 1'b0);
    stat(32'h0000_1005);
    setc(IN_OV_HI, 1'b0);
    host.write_reg(CFG_OFS, 32'h3);
    settle(6);
    check({31'h0, overvoltage_threshold_select}, 32'h1, "ov select");
    pins(1'b0, 1'b1, 1'b0);
    setc(IN_OV_HI, 1'b1);
    settle(6);
    pins(1'b1, 1'b0, 1'b0);
    setc(IN_OV_LO, 1'b0);
    setc(IN_OV_HI, 1'b0);
    settle(6);
    stat(32'h0000_0005);
    host.clear_faults();
    // FET overcurrent in all four modes, 1 us deglitch, long retry
    for (int m = 0; m < 4; m++) begin
      host.write_reg(CFG_OFS, (32'(m) << OVERCURRENT_RESPONSE_MODE_LSB) | (32'ha << OVERCURRENT_LEVEL_LSB) | (32'h1 << OVERCURRENT_RETRY_TIME_BIT));
      setf(6'h04);
      settle(20);
      setf(6'h00);
      settle(30);
      check({28'h0, overcurrent_level}, 32'ha, "oc level");
      stat(32'h0);
      setf(6'h04);
      settle(50);
      pins(m < 2, m >= 2, 1'b0);
      setf(6'h00);
      settle(8);
      pins(m < 2, m >= 2, 1'b0);
      settle(200);
      pins(m == 0, m != 0, 1'b0);
      stat(m == 3 ? 32'h0 : (32'h0109 | (m == 0 ? 32'h1000 : 32'h0)));
      host.clear_faults();
      settle(6);
      pins(1'b0, 1'b1, 1'b0);
      stat(32'h0);
    end
    // Limit threshold follows the loop state
    host.write_reg(LIM_OFS, 32'h005a_a517);
    settle(3);
    check({24'h0, limit_threshold}, 32'ha5, "closed limit");
    @(posedge clk);
    cl <= 1'b0;
    settle(3);
    check({24'h0, limit_threshold}, 32'h5a, "open limit");
    // Cycle limit modes 0 to 8, retry count of one
    for (int m = 0; m < 9; m++) begin
      act = m < 6;
      rep = m == 0 || m == 2 || m == 4;
      host.write_reg(LIM_OFS, {16'h005a, 8'ha5, 4'h1, 4'(m)});
      setc(IN_LIMIT, 1'b1);
      settle(6);
      pins(1'b0, !rep, act);
      stat((m < 7 ? 32'h20 : 32'h0) | ((rep || m == 6) ? 32'h10 : 32'h0) | (act ? 32'h2000 : 32'h0));
      setc(IN_LIMIT, 1'b0);
      settle(6);
      still = act && m != 2 && m != 3;
      pins(1'b0, !(still && rep), still);
      pulse_pwm();
      settle(3);
      still = m == 4 || m == 5;
      pins(1'b0, !(still && rep), still);
      pulse_pwm();
      settle(3);
      pins(1'b0, 1'b1, 1'b0);
      stat(((rep || m == 6) ? 32'h10 : 32'h0) | (m == 6 ? 32'h20 : 32'h0));
      host.clear_faults();
      stat(32'h0);
    end
    // Supply and buck events reset the device and its configuration
    foreach (srcs[k]) begin
      host.write_reg(CFG_OFS, 32'h3);
      setc(srcs[k], 1'b1);
      settle(srcs[k] == IN_BUCK_OC ? 50 : 6);
      check({27'h0, device_reset, pump_disable, fet_disable, fault_indicator_n, buck_switches_off},
            {27'h0, 4'hf, srcs[k] == IN_BUCK_UNDERVOLTAGE}, "reset pins");
      setc(srcs[k], 1'b0);
      settle(8);
      check({27'h0, device_reset, pump_disable, fet_disable, fault_indicator_n, buck_switches_off},
            32'h2, "after reset");
      host.read_reg(CFG_OFS, rd);
      check(rd, CFG_RST, "cfg cleared");
    end
    print_verdict();
  end
endmodule
